// ==== rtl/apc_cfg.svh ====
`ifndef APC_CFG_SVH
`define APC_CFG_SVH
// ==============================================================
// register byte offsets
`define APC_OFF_SC1 8'h00
`define APC_OFF_SC2 8'h04
`define APC_OFF_RES_HI 8'h08
`define APC_OFF_RES_LO 8'h0c
`define APC_OFF_CV_HI 8'h10
`define APC_OFF_CV_LO 8'h14
`define APC_OFF_CFG 8'h18
`define APC_OFF_ISO_LO 8'h1c
`define APC_OFF_ISO_MID 8'h20
`define APC_OFF_ISO_HI 8'h24
// ==============================================================
// reset values
`define APC_RST_SC1 8'h1f
`define APC_RST_BYTE 8'h00
// ==============================================================
// field positions and codes
`define APC_SC1_CONVERSION_COMPLETE_FLAG 7
`define APC_SC2_ACTIVE 7
`define APC_CH_OFF 5'h1f
`define APC_MODE_8 2'h0
`define APC_MODE_10 2'h2
`define APC_CLK_BUS 2'h0
`define APC_CLK_HALF 2'h1
`define APC_CLK_ALT 2'h2
`define APC_CLK_ASYNC 2'h3
`define APC_MAX10 10'h3ff
`define APC_MAX8 8'hff
`define APC_RESP_OK 2'h0
`define APC_RESP_ERR 2'h2
`endif

// ==== rtl/apc_pkg.sv ====
`default_nettype none
// ==============================================================
// shared types
package apc_pkg;
   // command bundle to the analog converter core
   typedef struct packed {
      logic start;         // one-cycle start pulse
      logic abort;         // one-cycle abort pulse
      logic active;        // conversion under way
      logic [4:0] channel; // selected channel
      logic mode_10bit;    // 1: 10-bit, 0: 8-bit
      logic long_sample;   // long sample time
      logic low_power;     // low power configuration
   } apc_cmd_t;
   // sequencer states, gray along idle -> convert
   typedef enum logic [1:0] {
      APC_IDLE = 2'b00,
      APC_CONVERT = 2'b01
   } apc_state_t;
endpackage : apc_pkg
`default_nettype wire

// ==== rtl/apc_adc_control.sv ====
`include "apc_cfg.svh"
`default_nettype none
module apc_adc_control
   import apc_pkg::*;
(
   input wire logic aclk,                  // bus clock
   input wire logic aresetn,               // sync reset, low
   input wire logic [7:0] s_axi_awaddr,    // write address
   input wire logic s_axi_awvalid,         // write address valid
   output logic s_axi_awready,             // write address ready
   input wire logic [31:0] s_axi_wdata,    // write data
   input wire logic [3:0] s_axi_wstrb,     // byte enables
   input wire logic s_axi_wvalid,          // write data valid
   output logic s_axi_wready,              // write data ready
   output logic [1:0] s_axi_bresp,         // write response
   output logic s_axi_bvalid,              // write response valid
   input wire logic s_axi_bready,          // write response ready
   input wire logic [7:0] s_axi_araddr,    // read address
   input wire logic s_axi_arvalid,         // read address valid
   output logic s_axi_arready,             // read address ready
   output logic [31:0] s_axi_rdata,        // read data
   output logic [1:0] s_axi_rresp,         // read response
   output logic s_axi_rvalid,              // read data valid
   input wire logic s_axi_rready,          // read data ready
   input wire logic hw_trigger_input,      // async trigger pin
   input wire logic alternate_clock,       // alternate source
   input wire logic internal_async_clock,  // async source
   input wire logic low_power_wait,        // wait or light stop
   input wire logic conv_done,             // core result ready
   input wire logic [10:0] conv_raw,       // core raw result
   output apc_cmd_t conv_cmd,              // command to core
   output logic converter_clock,           // converter clock tick
   output logic async_clock_run,           // keep async osc on
   output logic conversion_irq,            // interrupt level
   input wire logic [23:0] port_out,       // port data out
   input wire logic [23:0] port_oe,        // port drive enable
   input wire logic [23:0] port_pullup,    // port pullup request
   input wire logic [23:0] pin_in,         // pad level
   output logic [23:0] pad_out,            // pad data out
   output logic [23:0] pad_oe,             // pad drive enable
   output logic [23:0] pad_pullup,         // pad pullup enable
   output logic [23:0] pad_in_enable,      // pad input buffer on
   output logic [23:0] port_read_data      // port read value
);
   // ===========================================================
   // register state
   logic conversion_complete_flag, conversion_irq_enable, adco;
   logic [4:0] chan;
   logic hw_en, cmp_en, cmp_gt;
   logic [1:0] res_hi, cv_hi;
   logic [7:0] res_lo, cv_lo, cfg;
   logic [23:0] iso;
   apc_state_t state;
   // ===========================================================
   // synchronisers: pins, trigger and foreign clocks
   logic [26:0] sync1, sync2;
   logic trig_q, alt_q, async_q, half_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {internal_async_clock, alternate_clock,
                   hw_trigger_input, pin_in};
         sync2 <= sync1;
      end
   end
   // edge history only reads the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_q <= 1'b0;
         alt_q <= 1'b0;
         async_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         trig_q <= sync2[24];
         alt_q <= sync2[25];
         async_q <= sync2[26];
         half_q <= ~half_q;
      end
   end
   wire trig_rise = sync2[24] & ~trig_q;
   // ===========================================================
   // axi4-lite write channel: address and data in either order
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic w_lane0;
   wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
   wire wr_en = wr_fire & w_lane0;
   wire [7:0] wr_byte = w_data[7:0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready;
         s_axi_wready <= ~w_held & ~s_axi_wready;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end
   // address check shared by both directions
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `APC_OFF_ISO_HI);
   endfunction
   // write response; unmapped offsets answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `APC_RESP_OK;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_addr) ? `APC_RESP_OK : `APC_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   wire wr_sc1 = wr_en && aw_addr == `APC_OFF_SC1;
   wire wr_sc2 = wr_en && aw_addr == `APC_OFF_SC2;
   wire wr_cfg = wr_en && aw_addr == `APC_OFF_CFG;
   wire wr_cvh = wr_en && aw_addr == `APC_OFF_CV_HI;
   wire wr_cvl = wr_en && aw_addr == `APC_OFF_CV_LO;
   // ===========================================================
   // conversion start, abort and result path
   wire disabled = (chan == `APC_CH_OFF);
   wire mode10 = (cfg[3:2] == `APC_MODE_10);
   // any mode-changing write invalidates the running conversion
   wire abort_req = wr_sc1 | wr_sc2 | wr_cfg | wr_cvh | wr_cvl;
   wire sw_start = wr_sc1 && wr_byte[4:0] != `APC_CH_OFF
                   && !hw_en;
   // edges count only while idle, so a running or continuous
   // sequence never sees them
   wire hw_start = hw_en & trig_rise & ~disabled
                   & (state == APC_IDLE);
   logic [10:0] sum10;
   logic [8:0] sum8;
   logic [9:0] rounded, cmp_val, diff;
   logic cmp_ok;
   // round half up, saturating at full scale
   always_comb begin
      sum10 = {1'b0, conv_raw[10:1]} + {10'h000, conv_raw[0]};
      sum8 = {1'b0, conv_raw[8:1]} + {8'h00, conv_raw[0]};
      if (mode10) begin
         rounded = sum10[10] ? `APC_MAX10 : sum10[9:0];
         cmp_val = {cv_hi, cv_lo};
      end else begin
         rounded = {2'h0, sum8[8] ? `APC_MAX8 : sum8[7:0]};
         cmp_val = {2'h0, cv_lo};
      end
      diff = rounded - cmp_val;
      if (!mode10) diff[9:8] = 2'h0;
      cmp_ok = cmp_gt ? (rounded >= cmp_val) : (rounded < cmp_val);
   end
   wire done_ok = (state == APC_CONVERT) & conv_done & ~abort_req;
   wire transfer = done_ok & (~cmp_en | cmp_ok);
   // ===========================================================
   // sequencer: idle until started, lowest power while idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= APC_IDLE;
      end else if (sw_start | hw_start) begin
         state <= APC_CONVERT; // start already checks the new channel
      end else if (disabled) begin
         state <= APC_IDLE;
      end else if (abort_req) begin
         state <= APC_IDLE;
      end else if (done_ok) begin
         state <= adco ? APC_CONVERT : APC_IDLE;
      end
   end
   // core command, restarted in the same edge when continuous
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_cmd <= '0;
      end else begin
         conv_cmd.start <= sw_start | hw_start
                           | (done_ok & adco & ~disabled);
         conv_cmd.abort <= abort_req & (state == APC_CONVERT);
         conv_cmd.active <= (state == APC_CONVERT);
         conv_cmd.channel <= wr_sc1 ? wr_byte[4:0] : chan;
         conv_cmd.mode_10bit <= mode10;
         conv_cmd.long_sample <= cfg[4];
         conv_cmd.low_power <= cfg[7];
      end
   end
   // ===========================================================
   // clock select and divide, running only while converting
   logic src_tick;
   logic [2:0] div_cnt;
   wire [2:0] div_last = 3'((4'h1 << cfg[6:5]) - 4'h1);
   always_comb begin
      case (cfg[1:0])
         `APC_CLK_BUS: src_tick = 1'b1;
         `APC_CLK_HALF: src_tick = half_q;
         `APC_CLK_ALT: src_tick = sync2[25] & ~alt_q;
         `APC_CLK_ASYNC: src_tick = sync2[26] & ~async_q;
         default: src_tick = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || state == APC_IDLE) begin
         div_cnt <= '0;
         converter_clock <= 1'b0;
      end else begin
         converter_clock <= src_tick && div_cnt == div_last;
         if (src_tick) begin
            div_cnt <= (div_cnt == div_last) ? 3'h0 : div_cnt + 3'h1;
         end
      end
   end
   // async oscillator kept alive through wait and light stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         async_clock_run <= 1'b0;
      end else begin
         async_clock_run <= cfg[1:0] == `APC_CLK_ASYNC
                            && (state == APC_CONVERT
                                || (low_power_wait && !disabled));
      end
   end
   // ===========================================================
   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {conversion_irq_enable, adco, chan} <= 7'(`APC_RST_SC1);
         {hw_en, cmp_en, cmp_gt} <= 3'h0;
         cfg <= `APC_RST_BYTE;
         cv_hi <= 2'h0;
         cv_lo <= `APC_RST_BYTE;
         iso <= '0;
      end else begin
         if (wr_sc1) {conversion_irq_enable, adco, chan} <= wr_byte[6:0];
         if (wr_sc2) {hw_en, cmp_en, cmp_gt} <= wr_byte[6:4];
         if (wr_cfg) cfg <= wr_byte;
         if (wr_cvh) cv_hi <= wr_byte[1:0];
         if (wr_cvl) cv_lo <= wr_byte;
         if (wr_en && aw_addr == `APC_OFF_ISO_LO)
            iso[7:0] <= wr_byte;
         if (wr_en && aw_addr == `APC_OFF_ISO_MID)
            iso[15:8] <= wr_byte;
         if (wr_en && aw_addr == `APC_OFF_ISO_HI)
            iso[23:16] <= wr_byte;
      end
   end
   // result and complete flag; an SC1 write aborts a same-cycle completion, so the clear wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_hi <= 2'h0;
         res_lo <= `APC_RST_BYTE;
         conversion_complete_flag <= 1'b0;
      end else begin
         if (transfer) begin
            res_hi <= cmp_en ? diff[9:8] : rounded[9:8];
            res_lo <= cmp_en ? diff[7:0] : rounded[7:0];
            conversion_complete_flag <= 1'b1;
         end else if (wr_sc1) begin
            conversion_complete_flag <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conversion_irq <= 1'b0;
      end else begin
         conversion_irq <= (conversion_complete_flag | transfer) & conversion_irq_enable;
      end
   end
   // ===========================================================
   // axi4-lite read channel, answer one cycle after address
   logic [7:0] rd_byte;
   always_comb begin
      case (s_axi_araddr)
         `APC_OFF_SC1: rd_byte = {conversion_complete_flag, conversion_irq_enable, adco, chan};
         `APC_OFF_SC2: rd_byte = {state == APC_CONVERT, hw_en,
                                  cmp_en, cmp_gt, 4'h0};
         `APC_OFF_RES_HI: rd_byte = {6'h00, res_hi};
         `APC_OFF_RES_LO: rd_byte = res_lo;
         `APC_OFF_CV_HI: rd_byte = {6'h00, cv_hi};
         `APC_OFF_CV_LO: rd_byte = cv_lo;
         `APC_OFF_CFG: rd_byte = cfg;
         `APC_OFF_ISO_LO: rd_byte = iso[7:0];
         `APC_OFF_ISO_MID: rd_byte = iso[15:8];
         `APC_OFF_ISO_HI: rd_byte = iso[23:16];
         default: rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `APC_RESP_OK;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= mapped(s_axi_araddr) ? `APC_RESP_OK
                                                : `APC_RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // ===========================================================
   // per-pin isolation gating
   genvar gi;
   generate
      for (gi = 0; gi < 24; gi++) begin : g_pin
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pad_out[gi] <= 1'b0;
               pad_oe[gi] <= 1'b0;
               pad_pullup[gi] <= 1'b0;
               pad_in_enable[gi] <= 1'b1;
               port_read_data[gi] <= 1'b0;
            end else begin
               pad_out[gi] <= port_out[gi];
               pad_oe[gi] <= port_oe[gi] & ~iso[gi];
               pad_pullup[gi] <= port_pullup[gi] & ~iso[gi];
               pad_in_enable[gi] <= ~iso[gi];
               port_read_data[gi] <= sync2[gi] & ~iso[gi];
            end
         end
      end
   endgenerate
endmodule // apc_adc_control
`default_nettype wire

// ==== tb/apc_core_model.sv ====
`default_nettype none
// ==============================================================
// analog core stand-in: answers a start after a set delay
module apc_core_model
   import apc_pkg::*;
(
   input wire logic aclk,          // bus clock
   input wire logic aresetn,       // sync reset
   input wire apc_cmd_t cmd,       // command in
   input wire logic [10:0] raw_val, // result to return
   input wire logic [7:0] delay,   // cycles per conversion
   output logic conv_done,         // result pulse
   output logic [10:0] conv_raw    // raw result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy;
   logic [7:0] cnt;
   // a restart wins over the abort that comes with the same write
   always_ff @(posedge aclk) begin
      conv_done <= 1'b0;
      if (!aresetn) begin
         busy <= 1'b0;
      end else if (cmd.start) begin
         busy <= 1'b1;
         cnt <= delay;
      end else if (cmd.abort) begin
         busy <= 1'b0;
      end else if (busy && cnt == 8'h00) begin
         busy <= 1'b0;
         conv_done <= 1'b1;
      end else if (busy) begin
         cnt <= cnt - 8'h01;
      end
   end
   // bus is meaningless outside the pulse, so show the inverse there
   assign conv_raw = conv_done ? raw_val : ~raw_val;
endmodule // apc_core_model
`default_nettype wire

// ==== tb/apc_adc_control_chk.sv ====
`include "apc_cfg.svh"
`default_nettype none
// ==============================================================
// port-level checker
module apc_adc_control_chk
   import apc_pkg::*;
(
   input wire logic aclk, // clk
   input wire logic aresetn, // rst
   input wire logic s_axi_wvalid, // w
   input wire logic s_axi_wready, // w
   input wire logic s_axi_bvalid, // b
   input wire logic s_axi_bready, // b
   input wire logic [1:0] s_axi_bresp, // b
   input wire logic s_axi_arvalid, // ar
   input wire logic s_axi_arready, // ar
   input wire logic s_axi_rvalid, // r
   input wire logic s_axi_rready, // r
   input wire logic [31:0] s_axi_rdata, // r
   input wire apc_cmd_t conv_cmd, // core cmd
   input wire logic [23:0] pin_in, // pads
   input wire logic [23:0] pad_oe, // drive
   input wire logic [23:0] pad_pullup, // pullup
   input wire logic [23:0] pad_in_enable, // input buf
   input wire logic [23:0] port_read_data // port read
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==============================================================
   // bus handshakes
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_r_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   a_wr_answer: assert property (s_axi_wvalid && s_axi_wready |->
      ##[0:3] s_axi_bvalid) else $error("no write response");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no read response");
   a_b_hold: assert property (s_b_wait |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write response dropped");
   a_r_hold: assert property (s_r_wait |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read data dropped");
   // ==============================================================
   // pins and converter commands
   a_iso_drive: assert property ((pad_oe & ~pad_in_enable) == 24'h0)
      else $error("isolated pin still driven");
   a_iso_pull: assert property ((pad_pullup & ~pad_in_enable) == 24'h0)
      else $error("isolated pin keeps pullup");
   a_read_zero: assert property
      ((port_read_data & ~$past(pin_in, 3)) == 24'h0)
      else $error("port reads a one from a low pin");
   a_iso_read: assert property
      ((port_read_data & ~pad_in_enable) == 24'h0)
      else $error("isolated pin reads as one");
   a_start_off: assert property (conv_cmd.start |->
      conv_cmd.channel != `APC_CH_OFF) else $error("start while off");
   a_abort_pulse: assert property (conv_cmd.abort |=> !conv_cmd.abort)
      else $error("abort longer than a pulse");
endmodule // apc_adc_control_chk
bind apc_adc_control apc_adc_control_chk chk_i (.aclk, .aresetn,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .conv_cmd, .pin_in, .pad_oe,
   .pad_pullup, .pad_in_enable, .port_read_data);
`default_nettype wire

// ==== tb/apc_adc_control_tb.sv ====
`include "apc_cfg.svh"
`default_nettype none
module apc_adc_control_tb;
   import apc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, hw_trigger_input;
   logic conv_done, conversion_irq, converter_clock;
   logic slow, lpw, async_clock_run;
   logic [7:0] s_axi_awaddr, s_axi_araddr, delay, rd;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [10:0] conv_raw, raw_val;
   logic [23:0] port_out, port_oe, port_pullup, pin_in, pad_out, pad_oe;
   logic [23:0] pad_pullup, pad_in_enable, port_read_data;
   apc_cmd_t conv_cmd;
   int fails, total_checks, starts, s0, p;
   apc_adc_control apc_adc_control_i (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .hw_trigger_input, .alternate_clock(slow),
      .internal_async_clock(slow), .low_power_wait(lpw), .conv_done,
      .conv_raw, .conv_cmd, .converter_clock, .async_clock_run,
      .conversion_irq, .port_out, .port_oe, .port_pullup, .pin_in,
      .pad_out, .pad_oe, .pad_pullup, .pad_in_enable, .port_read_data);
   apc_core_model apc_core_model_i (.aclk, .aresetn, .cmd(conv_cmd),
      .raw_val, .delay, .conv_done, .conv_raw);
   // ==============================================================
   // clock and start counter
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // slow source for the alternate and async inputs, four bus periods
   initial begin
      slow = 1'b0;
      forever #200 slow = ~slow;
   end
   always @(posedge aclk) begin
      if (conv_cmd.start === 1'b1) starts++;
   end
   // ==============================================================
   // tasks
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic tmo;
      fails++;
      $display("Error %0t: wait ran out", $time);
      wrap_up;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // address and data go up together; each drops once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) tmo;
   endtask
   task automatic rdt(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      rd = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) tmo;
   endtask
   task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
      rdt(a);
      chk(rd, e);
   endtask
   // polls the complete flag; a lost completion ends in the timeout
   task automatic conv(input logic [7:0] c, input logic [10:0] r);
      int n;
      raw_val <= r;
      wr(`APC_OFF_CFG, c);
      wr(`APC_OFF_SC1, 8'h43);
      for (n = 0; n < 30; n++) begin
         rdt(`APC_OFF_SC1);
         if (rd[7] === 1'b1) break;
      end
      if (n == 30) tmo;
   endtask
   // edges from one divided tick to the next
   task automatic per;
      int n;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (converter_clock === 1'b1) break;
      end
      for (p = 1; p < 40; p++) begin
         @(posedge aclk);
         if (converter_clock === 1'b1) break;
      end
   endtask
   // ==============================================================
   // main sequence
   logic [7:0] tcfg[3] = '{8'h08, 8'h08, 8'h00};
   logic [10:0] traw[3] = '{11'h4ff, 11'h7ff, 11'h0a5};
   logic [7:0] thi[3] = '{8'h02, 8'h03, 8'h00};
   logic [7:0] tlo[3] = '{8'h80, 8'hff, 8'h53};
   logic [7:0] dcfg[7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h61, 8'h02, 8'h03};
   int dper[7] = '{1, 2, 4, 8, 16, 4, 4};
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, hw_trigger_input} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'h1;
      {port_out, port_oe, port_pullup, pin_in} = 96'h0;
      raw_val = 11'h0;
      lpw = 1'b0;
      delay = 8'h14;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chkrd(`APC_OFF_SC1, `APC_RST_SC1);
      chkrd(`APC_OFF_CFG, 8'h00);
      for (int i = 0; i < 3; i++) begin
         chkrd(8'(`APC_OFF_ISO_LO + 4 * i), 8'h00);
      end
      wr(8'h30, 8'h00);
      chk(rs, `APC_RESP_ERR);
      rdt(8'h30);
      chk(rs, `APC_RESP_ERR);
      // isolate pin 0 and pin 23 with every port path active
      wr(`APC_OFF_ISO_LO, 8'h01);
      wr(`APC_OFF_ISO_HI, 8'h80);
      {port_out, port_oe, port_pullup, pin_in} <= {4{24'hffffff}};
      repeat (5) @(posedge aclk);
      chk(pad_oe, 24'h7ffffe);
      chk(pad_out, 24'hffffff);
      chk(pad_pullup, 24'h7ffffe);
      chk(pad_in_enable, 24'h7ffffe);
      chk(port_read_data, 24'h7ffffe);
      chkrd(`APC_OFF_ISO_HI, 8'h80);
      for (int i = 0; i < 3; i++) begin
         conv(tcfg[i], traw[i]);
         chk(conversion_irq, 1'b1);
         chkrd(`APC_OFF_RES_HI, thi[i]);
         chkrd(`APC_OFF_RES_LO, tlo[i]);
      end
      s0 = starts;
      wr(`APC_OFF_SC1, 8'h1f);
      repeat (10) @(posedge aclk);
      chk(conversion_irq, 1'b0);
      chk(starts - s0, 0);
      wr(`APC_OFF_SC2, 8'h30);
      wr(`APC_OFF_CV_LO, 8'h50);
      conv(8'h00, 11'h0a5);
      chkrd(`APC_OFF_RES_LO, 8'h03);
      raw_val <= 11'h021;
      wr(`APC_OFF_SC1, 8'h03);
      repeat (60) @(posedge aclk);
      chkrd(`APC_OFF_SC1, 8'h03);
      wr(`APC_OFF_SC2, 8'h00);
      delay <= 8'h28;
      wr(`APC_OFF_SC1, 8'h03);
      wr(`APC_OFF_CFG, 8'h00);
      repeat (60) @(posedge aclk);
      chkrd(`APC_OFF_SC1, 8'h03);
      chk(conv_cmd.active, 1'b0);
      delay <= 8'h0a;
      s0 = starts;
      wr(`APC_OFF_SC1, 8'h23);
      repeat (100) @(posedge aclk);
      chk(32'(starts - s0 > 3), 1);
      delay <= 8'hc8;
      for (int i = 0; i < 7; i++) begin
         wr(`APC_OFF_CFG, dcfg[i]);
         wr(`APC_OFF_SC1, 8'h03);
         per;
         chk(p, dper[i]);
         chk(async_clock_run, dcfg[i][1:0] == 2'h3);
      end
      wr(`APC_OFF_SC1, 8'h1f);
      delay <= 8'h28;
      wr(`APC_OFF_SC2, 8'h40);
      wr(`APC_OFF_SC1, 8'h03);
      s0 = starts;
      for (int i = 0; i < 2; i++) begin
         hw_trigger_input <= 1'b1;
         repeat (4) @(posedge aclk);
         hw_trigger_input <= 1'b0;
         repeat (10) @(posedge aclk);
      end
      repeat (60) @(posedge aclk);
      chk(starts - s0, 1);
      chkrd(`APC_OFF_SC1, 8'h83);
      // idle with the async source picked: wait keeps it running
      wr(`APC_OFF_CFG, 8'h03);
      lpw <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(async_clock_run, 1'b1);
      wrap_up;
   end
   // guard against a hang anywhere
   initial begin
      repeat (60000) @(posedge aclk);
      tmo;
   end
endmodule // apc_adc_control_tb
`default_nettype wire
